/* File: core/cmd_pkg.sv */
// Purpose: constants and carriers for the seek / sense / set-features command logic
// Assumes: task-file registers reached over a plain address/strobe port
// Notes:   byte-wide registers sit in the low bits of each index
package cmd_pkg;
   // register indices (byte address = index)
   localparam logic [3:0] IDX_FEATURE   = 4'h1;
   localparam logic [3:0] IDX_SECCNT    = 4'h2;
   localparam logic [3:0] IDX_SECNUM    = 4'h3;
   localparam logic [3:0] IDX_CYLLO     = 4'h4;
   localparam logic [3:0] IDX_CYLHI     = 4'h5;
   localparam logic [3:0] IDX_DEVHEAD   = 4'h6;
   localparam logic [3:0] IDX_COMMAND   = 4'h7;
   localparam logic [3:0] IDX_ERROR     = 4'h8;
   localparam logic [3:0] IDX_STATUS    = 4'h9;
   localparam logic [3:0] IDX_FLAGS     = 4'ha;
   localparam logic [3:0] IDX_XFER      = 4'hb;
   localparam logic [3:0] IDX_APM       = 4'hc;
   localparam logic [3:0] IDX_SATA      = 4'hd;
   localparam logic [3:0] IDX_TEMP      = 4'he;
   // command codes
   localparam logic [3:0] CMD_SEEK_HI   = 4'h7;
   localparam logic [7:0] CMD_SENSE     = 8'hf0;
   localparam logic [7:0] CMD_SETFEAT   = 8'hef;
   localparam logic [7:0] SENSE_FEAT    = 8'h01;
   // set-features subcodes
   localparam logic [7:0] SF_WC_EN      = 8'h02;
   localparam logic [7:0] SF_XFER       = 8'h03;
   localparam logic [7:0] SF_APM_EN     = 8'h05;
   localparam logic [7:0] SF_PUIS_EN    = 8'h06;
   localparam logic [7:0] SF_SPINUP     = 8'h07;
   localparam logic [7:0] SF_SATA_EN    = 8'h10;
   localparam logic [7:0] SF_HOSTTIME   = 8'h43;
   localparam logic [7:0] SF_EPC        = 8'h4a;
   localparam logic [7:0] SF_RLA_DIS    = 8'h55;
   localparam logic [7:0] SF_REVERT_DIS = 8'h66;
   localparam logic [7:0] SF_WC_DIS     = 8'h82;
   localparam logic [7:0] SF_APM_DIS    = 8'h85;
   localparam logic [7:0] SF_PUIS_DIS   = 8'h86;
   localparam logic [7:0] SF_SATA_DIS   = 8'h90;
   localparam logic [7:0] SF_RLA_EN     = 8'haa;
   localparam logic [7:0] SF_REVERT_EN  = 8'hcc;
   // temperature code limits
   localparam int         TEMP_MIN_C    = -20;
   localparam int         TEMP_MAX_C    = 107;
   localparam logic [7:0] TEMP_CODE_LO  = 8'h00;
   localparam logic [7:0] TEMP_CODE_HI  = 8'hff;
   // status / error bit positions
   localparam int ST_BSY = 7;
   localparam int ST_RDY = 6;
   localparam int ST_DSC = 4;
   localparam int ST_DRQ = 3;
   localparam int ST_ERR = 0;
   localparam int ER_ABT = 2;
   // device/head fields
   localparam int DH_LBA = 6;
   // flags register layout
   localparam int FL_WC     = 0;
   localparam int FL_RLA    = 1;
   localparam int FL_REVERT = 2;
   localparam int FL_RELINT = 3;
   localparam int FL_APM    = 4;
   localparam int FL_PUIS   = 5;
   localparam int FL_STBY   = 6;
   localparam logic [7:0] APM_ABORT_LO = 8'h00;
   localparam logic [7:0] APM_ABORT_HI = 8'hff;
   localparam logic [7:0] RDY_STATUS   = 8'h50;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_t;

   typedef struct packed {
      logic       wc;
      logic       rla;
      logic       revert;
      logic       relint;
      logic       apm;
      logic       puis;
      logic       standby;
   } feat_t;
endpackage : cmd_pkg

/* File: core/cmd_exec.sv */
// Purpose: executes seek, sense-condition and set-features commands
// Assumes: host writes parameters then command; inputs synchronous to core_clk
// Notes:   commands complete in the cycle after the command write
`timescale 1ns/1ns
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Contract
// - command upper nibble 0111 is a seek to given track and head.
// - seek runs even on unformatted media, no format abort.
// - CHS seek: cylinder from high/low, head from device/head field.
// - LBA seek: sector, cyl low, cyl high, head give bits 0-27.
// - LBA seek completion returns current address in same registers.
// - F0h is temperature sense, accepted even in power-up standby.
// - sense needs feature 01h, otherwise abort.
// - sense result byte returned in sector count.
// - codes 01h-FEh mean code/2 minus 20 degrees.
// - 00h at or below -20 C, FFh above 107 C.
// - set-features with undefined subcode sets abort.
// - 02h enables, 82h disables write cache.
// - 03h sets transfer mode from sector count.
// - 05h enables APM with level, 85h disables.
// - 06h/86h power-up standby on/off; 07h spins up.
// - 10h/90h enable/disable serial feature named in sector count.
// - 43h records host sector time; 4Ah accepted as EPC.
// - AAh enables, 55h disables read look-ahead.
// - CCh enables, 66h disables reverting to power-on defaults.
// - reset: cache on, look-ahead on, revert off, release interrupt off.
// - transfer mode: upper five bits type, lower three mode.
module cmd_exec (
   input  wire  logic              core_clk,
   input  wire  logic              rst_n,
   input  wire  cmd_pkg::reg_req_t req,
   input  wire  logic signed [9:0] temp_half_c,
   input  wire  logic              standby_strap,
   output logic [7:0]              rdata,
   output logic [27:0]             seek_target,
   output logic                    seek_lba,
   output logic                    seek_go,
   output logic                    spinup_go,
   output cmd_pkg::feat_t          feat
);
   import cmd_pkg::*;

   typedef enum logic [1:0] {IDLE, EXEC} state_t;
   state_t      state_r;
   logic [7:0]  feature_r, seccnt_r, secnum_r, cyllo_r, cylhi_r, devhead_r, cmd_r;
   logic [7:0]  error_r, status_r, xfer_r, apm_r, sata_r;
   logic [15:0] hosttime_r;
   logic [7:0]  temp_code;
   logic        sf_known;
   logic        strap_seen_r;
   logic        cmd_wr;
   logic        abort_nxt;

   assign cmd_wr = req.wr && req.addr == IDX_COMMAND;

   //////////////////////////////////////////////////////////////////////////
   // temperature encoding: input in half degrees, so code = half + 40
   always_comb begin
      if (temp_half_c <= 10'(2 * TEMP_MIN_C))
         temp_code = TEMP_CODE_LO;
      else if (temp_half_c > 10'(2 * TEMP_MAX_C))
         temp_code = TEMP_CODE_HI;
      else
         temp_code = 8'(temp_half_c - 10'(2 * TEMP_MIN_C));
   end

   always_comb begin
      case (feature_r)
         SF_WC_EN, SF_XFER, SF_APM_EN, SF_PUIS_EN, SF_SPINUP, SF_SATA_EN,
         SF_HOSTTIME, SF_EPC, SF_RLA_DIS, SF_REVERT_DIS, SF_WC_DIS,
         SF_APM_DIS, SF_PUIS_DIS, SF_SATA_DIS, SF_RLA_EN, SF_REVERT_EN:
            sf_known = 1'b1;
         default: sf_known = 1'b0;
      endcase
   end

   always_comb begin
      abort_nxt = 1'b0;
      if (cmd_r[7:4] == CMD_SEEK_HI)
         abort_nxt = 1'b0;
      else if (cmd_r == CMD_SENSE)
         abort_nxt = feature_r != SENSE_FEAT;
      else if (cmd_r == CMD_SETFEAT)
         abort_nxt = !sf_known ||
            (feature_r == SF_APM_EN &&
             (seccnt_r == APM_ABORT_LO || seccnt_r == APM_ABORT_HI));
      else
         abort_nxt = 1'b1;
   end

   //////////////////////////////////////////////////////////////////////////
   // parameter registers; seek in LBA mode writes back current address
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         feature_r <= 8'h00;
         seccnt_r  <= 8'h00;
         secnum_r  <= 8'h00;
         cyllo_r   <= 8'h00;
         cylhi_r   <= 8'h00;
         devhead_r <= 8'h00;
         cmd_r     <= 8'h00;
      end else if (state_r == EXEC) begin
         if (cmd_r == CMD_SENSE && !abort_nxt)
            seccnt_r <= temp_code;
         if (cmd_r[7:4] == CMD_SEEK_HI && devhead_r[DH_LBA]) begin
            secnum_r       <= seek_target[7:0];
            cyllo_r        <= seek_target[15:8];
            cylhi_r        <= seek_target[23:16];
            devhead_r[3:0] <= seek_target[27:24];
         end
      end else if (req.wr && status_r[ST_BSY] == 1'b0) begin
         case (req.addr)
            IDX_FEATURE: feature_r <= req.wdata;
            IDX_SECCNT:  seccnt_r  <= req.wdata;
            IDX_SECNUM:  secnum_r  <= req.wdata;
            IDX_CYLLO:   cyllo_r   <= req.wdata;
            IDX_CYLHI:   cylhi_r   <= req.wdata;
            IDX_DEVHEAD: devhead_r <= req.wdata;
            IDX_COMMAND: cmd_r     <= req.wdata;
            default: ;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n)
         state_r <= IDLE;
      else begin
         case (state_r)
            IDLE:    if (cmd_wr) state_r <= EXEC;
            EXEC:    state_r <= IDLE;
            default: state_r <= IDLE;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // seek: target latched and pulsed out in the execute cycle
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         seek_target <= 28'h0000000;
         seek_lba    <= 1'b0;
         seek_go     <= 1'b0;
      end else begin
         seek_go <= 1'b0;
         // gated by busy so a stray command write cannot launch a second seek
         if (cmd_wr && !status_r[ST_BSY] && req.wdata[7:4] == CMD_SEEK_HI) begin
            seek_lba <= devhead_r[DH_LBA];
            seek_go  <= 1'b1;
            if (devhead_r[DH_LBA])
               seek_target <= {devhead_r[3:0], cylhi_r, cyllo_r, secnum_r};
            else
               seek_target <= {devhead_r[3:0], 8'h00, cylhi_r, cyllo_r};
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // status and error; busy only during the execute cycle
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         status_r <= RDY_STATUS;
         error_r  <= 8'h00;
      end else if (cmd_wr && !status_r[ST_BSY]) begin
         status_r         <= 8'h00;
         status_r[ST_BSY] <= 1'b1;
         error_r          <= 8'h00;
      end else if (state_r == EXEC) begin
         status_r         <= RDY_STATUS;
         status_r[ST_ERR] <= abort_nxt;
         status_r[ST_DRQ] <= 1'b0;
         error_r[ER_ABT]  <= abort_nxt;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // feature state; sense is not gated by standby
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         feat.wc      <= 1'b1;
         feat.rla     <= 1'b1;
         feat.revert  <= 1'b0;
         feat.relint  <= 1'b0;
         feat.apm     <= 1'b0;
         feat.puis    <= 1'b0;
         feat.standby <= 1'b0;
         xfer_r       <= 8'h00;
         apm_r        <= 8'h00;
         sata_r       <= 8'h00;
         hosttime_r   <= 16'h0000;
         strap_seen_r <= 1'b0;
         spinup_go    <= 1'b0;
      end else begin
         spinup_go <= 1'b0;
         // standby strap caught once after reset release
         if (!strap_seen_r) begin
            strap_seen_r <= 1'b1;
            feat.standby <= standby_strap;
         end
         if (state_r == EXEC && cmd_r == CMD_SETFEAT && !abort_nxt) begin
            case (feature_r)
               SF_WC_EN:      feat.wc     <= 1'b1;
               SF_WC_DIS:     feat.wc     <= 1'b0;
               SF_XFER:       xfer_r      <= seccnt_r;
               SF_APM_EN: begin
                  feat.apm <= 1'b1;
                  apm_r    <= seccnt_r;
               end
               SF_APM_DIS:    feat.apm    <= 1'b0;
               SF_PUIS_EN:    feat.puis   <= 1'b1;
               SF_PUIS_DIS:   feat.puis   <= 1'b0;
               SF_SPINUP: begin
                  feat.standby <= 1'b0;
                  spinup_go    <= 1'b1;
               end
               SF_SATA_EN:    sata_r[seccnt_r[2:0]] <= 1'b1;
               SF_SATA_DIS:   sata_r[seccnt_r[2:0]] <= 1'b0;
               SF_HOSTTIME:   hosttime_r  <= {secnum_r, seccnt_r};
               SF_RLA_EN:     feat.rla    <= 1'b1;
               SF_RLA_DIS:    feat.rla    <= 1'b0;
               SF_REVERT_EN:  feat.revert <= 1'b1;
               SF_REVERT_DIS: feat.revert <= 1'b0;
               default: ;                                    // epc accepted, no state
            endcase
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // read port: data one cycle after the strobe, zero for unmapped
   always_ff @(posedge core_clk) begin
      if (!rst_n)
         rdata <= 8'h00;
      else if (req.rd) begin
         case (req.addr)
            IDX_FEATURE: rdata <= feature_r;
            IDX_SECCNT:  rdata <= seccnt_r;
            IDX_SECNUM:  rdata <= secnum_r;
            IDX_CYLLO:   rdata <= cyllo_r;
            IDX_CYLHI:   rdata <= cylhi_r;
            IDX_DEVHEAD: rdata <= devhead_r;
            IDX_COMMAND: rdata <= cmd_r;
            IDX_ERROR:   rdata <= error_r;
            IDX_STATUS:  rdata <= status_r;
            IDX_FLAGS:   rdata <= {1'b0, feat.standby, feat.puis, feat.apm,
                                   feat.relint, feat.revert, feat.rla, feat.wc};
            IDX_XFER:    rdata <= xfer_r;
            IDX_APM:     rdata <= apm_r;
            IDX_SATA:    rdata <= sata_r;
            IDX_TEMP:    rdata <= hosttime_r[7:0];
            default:     rdata <= 8'h00;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////
   property p_seek_go;
      @(posedge core_clk) disable iff (!rst_n)
      cmd_wr && req.wdata[7:4] == CMD_SEEK_HI && !status_r[ST_BSY] |=> seek_go;
   endproperty
   a_seek_go: assert property (p_seek_go) else $error("seek not issued");

   property p_no_fmt_abort;
      @(posedge core_clk) disable iff (!rst_n)
      state_r == EXEC && cmd_r[7:4] == CMD_SEEK_HI |=> !error_r[ER_ABT];
   endproperty
   a_no_fmt_abort: assert property (p_no_fmt_abort) else $error("seek aborted");

   property p_chs;
      @(posedge core_clk) disable iff (!rst_n)
      seek_go && !seek_lba |-> seek_target == {devhead_r[3:0], 8'h00, cylhi_r, cyllo_r};
   endproperty
   a_chs: assert property (p_chs) else $error("chs target bad");

   property p_lba;
      @(posedge core_clk) disable iff (!rst_n)
      seek_go && seek_lba |=> {devhead_r[3:0], cylhi_r, cyllo_r, secnum_r} == seek_target;
   endproperty
   a_lba: assert property (p_lba) else $error("lba writeback bad");

   property p_sense_abort;
      @(posedge core_clk) disable iff (!rst_n)
      state_r == EXEC && cmd_r == CMD_SENSE && feature_r != SENSE_FEAT
      |=> error_r[ER_ABT] && status_r[ST_ERR];
   endproperty
   a_sense_abort: assert property (p_sense_abort) else $error("sense not aborted");

   property p_sense_res;
      @(posedge core_clk) disable iff (!rst_n)
      state_r == EXEC && cmd_r == CMD_SENSE && feature_r == SENSE_FEAT
      |=> seccnt_r == $past(temp_code);
   endproperty
   a_sense_res: assert property (p_sense_res) else $error("sense result bad");

   property p_temp_hi;
      @(posedge core_clk) disable iff (!rst_n)
      temp_half_c > 10'sd214 |-> temp_code == 8'hff;
   endproperty
   a_temp_hi: assert property (p_temp_hi) else $error("hot code bad");

   property p_sf_abort;
      @(posedge core_clk) disable iff (!rst_n)
      state_r == EXEC && cmd_r == CMD_SETFEAT && !sf_known |=> error_r[ER_ABT];
   endproperty
   a_sf_abort: assert property (p_sf_abort) else $error("subcode not aborted");

   property p_wc;
      @(posedge core_clk) disable iff (!rst_n)
      state_r == EXEC && cmd_r == CMD_SETFEAT && feature_r == SF_WC_DIS |=> !feat.wc;
   endproperty
   a_wc: assert property (p_wc) else $error("cache not disabled");

   property p_rla;
      @(posedge core_clk) disable iff (!rst_n)
      state_r == EXEC && cmd_r == CMD_SETFEAT && feature_r == SF_RLA_DIS |=> !feat.rla;
   endproperty
   a_rla: assert property (p_rla) else $error("look-ahead not disabled");

   property p_revert;
      @(posedge core_clk) disable iff (!rst_n)
      state_r == EXEC && cmd_r == CMD_SETFEAT && feature_r == SF_REVERT_EN |=> feat.revert;
   endproperty
   a_revert: assert property (p_revert) else $error("revert not enabled");

   property p_apm;
      @(posedge core_clk) disable iff (!rst_n)
      state_r == EXEC && cmd_r == CMD_SETFEAT && feature_r == SF_APM_EN && !abort_nxt
      |=> feat.apm && apm_r == seccnt_r;
   endproperty
   a_apm: assert property (p_apm) else $error("apm level not taken");

   property p_spinup;
      @(posedge core_clk) disable iff (!rst_n)
      state_r == EXEC && cmd_r == CMD_SETFEAT && feature_r == SF_SPINUP
      |=> spinup_go && !feat.standby;
   endproperty
   a_spinup: assert property (p_spinup) else $error("spin-up not issued");

   property p_busy;
      @(posedge core_clk) disable iff (!rst_n)
      cmd_wr && !status_r[ST_BSY] |=> status_r[ST_BSY] ##1 !status_r[ST_BSY];
   endproperty
   a_busy: assert property (p_busy) else $error("busy window bad");

   property p_abort_done;
      @(posedge core_clk) disable iff (!rst_n)
      state_r == EXEC && abort_nxt |=> !status_r[ST_BSY] && !status_r[ST_DRQ] && status_r[ST_ERR];
   endproperty
   a_abort_done: assert property (p_abort_done) else $error("abort status bad");
endmodule : cmd_exec
`default_nettype wire

/* File: dv/host_model.sv */
// Purpose: host model driving the task-file register port
// Assumes: strobes launched by NBA right after a rising edge, one cycle long
// Notes:   released write data is inverted so a stale byte never looks valid
`timescale 1ns/1ns
`default_nettype none
module host_model (
   input  wire logic              core_clk,
   input  wire logic [7:0]        rdata,
   output var  cmd_pkg::reg_req_t req
);
   import cmd_pkg::*;
   initial req = '0;
   //////////////////////////////////////////////////////////////////////////////
   task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      req <= '{a, d, 1'b1, 1'b0};
      @(posedge core_clk);
      req <= '{a, ~d, 1'b0, 1'b0};
   endtask : write_reg
   task automatic read_reg(input logic [3:0] a, output logic [7:0] d);
      @(posedge core_clk);
      req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge core_clk);
      req <= '{a, 8'hff, 1'b0, 1'b0};
      @(negedge core_clk);
      d = rdata;
   endtask : read_reg
   // parameters first: the command write starts execution
   task automatic issue(input logic [7:0] f, sc, sn, cl, ch, dh, cmd);
      write_reg(IDX_FEATURE, f);
      write_reg(IDX_SECCNT, sc);
      write_reg(IDX_SECNUM, sn);
      write_reg(IDX_CYLLO, cl);
      write_reg(IDX_CYLHI, ch);
      write_reg(IDX_DEVHEAD, dh);
      write_reg(IDX_COMMAND, cmd);
   endtask : issue
endmodule : host_model
`default_nettype wire

/* File: dv/test_seek_sense_setfeature_cmds.sv */
// Purpose: self-checking bench for the seek / sense / set-features logic
// Assumes: standby strap held high, so every reset comes up in standby
// Notes:   random values from an lfsr seeded with a fixed start
`timescale 1ns/1ns
`default_nettype none
module test_seek_sense_setfeature_cmds;
   import cmd_pkg::*;
   logic              core_clk = 1'b0;
   logic              rst_n;
   reg_req_t          req;
   logic signed [9:0] temp_half_c;
   logic              standby_strap;
   logic [7:0]        rdata;
   logic [27:0]       seek_target;
   logic              seek_lba;
   logic              seek_go;
   logic              spinup_go;
   feat_t             feat;
   int                num_errors = 0;
   int                checks = 0;
   int                seeks = 0;
   int                spins = 0;
   int                v, k, n;
   logic [31:0]       lfsr = 32'h69d0;
   logic [31:0]       r;
   logic [27:0]       et;
   logic [7:0]        ef, sc, rd_v;
   logic              ab, lba;
   int                tv[10] = '{-512, -100, -41, -40, -39, 0, 213, 214, 215, 511};
   logic [7:0]        bad[3] = '{8'h00, 8'h02, 8'hff};
   logic [7:0]        xm[5] = '{8'h00, 8'h01, 8'h0c, 8'h22, 8'h46};
   logic [7:0]        sfc[18] = '{8'h82, 8'h02, 8'h55, 8'haa, 8'hcc, 8'h66, 8'h06, 8'h86,
                                  8'h05, 8'h85, 8'h4a, 8'h43, 8'h10, 8'h90, 8'h11, 8'h00,
                                  8'h05, 8'h05};
   logic [7:0]        sfs[18] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                  8'h80, 8'h00, 8'h00, 8'h12, 8'h03, 8'h03, 8'h00, 8'h00,
                                  8'h00, 8'hff};
   always #25 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      if (seek_go === 1'b1) seeks <= seeks + 1;
      if (spinup_go === 1'b1) spins <= spins + 1;
   end
   host_model u_host_model (.core_clk(core_clk), .rdata(rdata), .req(req));
   cmd_exec u_cmd_exec (.core_clk(core_clk), .rst_n(rst_n), .req(req),
      .temp_half_c(temp_half_c), .standby_strap(standby_strap), .rdata(rdata),
      .seek_target(seek_target), .seek_lba(seek_lba), .seek_go(seek_go),
      .spinup_go(spinup_go), .feat(feat));
   //////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction : rnd
   function automatic logic [7:0] exp_temp(input int h);
      int c;
      c = h + 40;
      if (c <= 0) return 8'h00;
      if (c >= 255) return 8'hff;
      return c[7:0];
   endfunction : exp_temp
   // flags byte: 0 cache, 1 look-ahead, 2 revert, 4 apm, 5 standby feature, 6 in standby
   function automatic logic [7:0] sf_model(input logic [7:0] c, s, f, output logic a);
      a = 1'b0;
      case (c)
         SF_WC_EN: f[FL_WC] = 1'b1;
         SF_WC_DIS: f[FL_WC] = 1'b0;
         SF_RLA_EN: f[FL_RLA] = 1'b1;
         SF_RLA_DIS: f[FL_RLA] = 1'b0;
         SF_REVERT_EN: f[FL_REVERT] = 1'b1;
         SF_REVERT_DIS: f[FL_REVERT] = 1'b0;
         SF_APM_EN: if (s == 8'h00 || s == 8'hff) a = 1'b1; else f[FL_APM] = 1'b1;
         SF_APM_DIS: f[FL_APM] = 1'b0;
         SF_PUIS_EN: f[FL_PUIS] = 1'b1;
         SF_PUIS_DIS: f[FL_PUIS] = 1'b0;
         SF_SPINUP: f[FL_STBY] = 1'b0;
         SF_XFER, SF_SATA_EN, SF_SATA_DIS, SF_HOSTTIME, SF_EPC: a = 1'b0;
         default: a = 1'b1;
      endcase
      return f;
   endfunction : sf_model
   task automatic check(input string what, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : final_report
   task automatic rr(input logic [3:0] a, input logic [31:0] exp, input string what);
      u_host_model.read_reg(a, rd_v);
      check(what, rd_v, exp);
   endtask : rr
   task automatic do_reset();
      @(posedge core_clk);
      rst_n <= 1'b0;
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      ef = 8'h43;
   endtask : do_reset
   task automatic chk_flags();
      rr(IDX_FLAGS, ef, "flags");
      check("feat", feat, {ef[0], ef[1], ef[2], ef[3], ef[4], ef[5], ef[6]});
   endtask : chk_flags
   // busy polling is bounded; a hung command ends the run
   task automatic run(input logic [7:0] f, s, sn, cl, ch, dh, cmd, input logic a);
      logic [7:0] st;
      int m;
      u_host_model.issue(f, s, sn, cl, ch, dh, cmd);
      st = 8'h80;
      m = 0;
      while (st[ST_BSY] !== 1'b0 && m < 20) begin
         u_host_model.read_reg(IDX_STATUS, st);
         m++;
      end
      if (st[ST_BSY] !== 1'b0) begin
         num_errors++;
         final_report();
      end
      check("status", st, a ? 8'h51 : RDY_STATUS);
      rr(IDX_ERROR, a ? 8'h04 : 8'h00, "error");
   endtask : run
   //////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n = 1'b0;
      temp_half_c = '0;
      standby_strap = 1'b1;
      do_reset();
      chk_flags();
      rr(4'hf, 8'h00, "unmapped");
      $display("test reset done");
      for (int i = 0; i < 16; i++) begin
         v = (i < 10) ? tv[i] : int'(rnd() % 400) - 100;
         @(posedge core_clk);
         temp_half_c <= v[9:0];
         run(SENSE_FEAT, 8'h00, 8'h00, 8'h00, 8'h00, 8'ha0, CMD_SENSE, 1'b0);
         rr(IDX_SECCNT, exp_temp(v), "temp code");
      end
      foreach (bad[i]) run(bad[i], 8'h00, 8'h00, 8'h00, 8'h00, 8'ha0, CMD_SENSE, 1'b1);
      $display("test sense done");
      run(SF_SPINUP, 8'h00, 8'h00, 8'h00, 8'h00, 8'ha0, CMD_SETFEAT, 1'b0);
      check("spinup pulses", spins, 1);
      ef[FL_STBY] = 1'b0;
      chk_flags();
      for (int i = 0; i < 48; i++) begin
         r = rnd();
         k = (i < 18) ? i : int'(r[15:8] % 18);
         sc = (i < 18) ? sfs[k] : r[7:0];
         ef = sf_model(sfc[k], sc, ef, ab);
         run(sfc[k], sc, 8'h00, 8'h00, 8'h00, 8'ha0, CMD_SETFEAT, ab);
         chk_flags();
         if (sfc[k] == SF_APM_EN && !ab) rr(IDX_APM, sc, "apm level");
         if (i == 11) rr(IDX_TEMP, 8'h12, "host time");
         if (i == 12) rr(IDX_SATA, 8'h08, "serial bits");
         if (i == 13) rr(IDX_SATA, 8'h00, "serial bits");
      end
      foreach (xm[i]) begin
         run(SF_XFER, xm[i], 8'h00, 8'h00, 8'h00, 8'ha0, CMD_SETFEAT, 1'b0);
         rr(IDX_XFER, xm[i], "transfer mode");
      end
      $display("test set features done");
      for (int i = 0; i < 10; i++) begin
         r = rnd();
         lba = i[0];
         n = seeks;
         run(8'h00, 8'h00, r[7:0], r[15:8], r[23:16], {2'b10 | lba, 2'b10, r[27:24]},
             {4'h7, r[31:28]}, 1'b0);
         check("seek pulses", seeks, n + 1);
         check("seek lba", seek_lba, lba);
         et = lba ? r[27:0] : {r[27:24], 8'h00, r[23:16], r[15:8]};
         check("target", seek_target, et);
         if (lba) begin
            rr(IDX_SECNUM, r[7:0], "lba low");
            rr(IDX_CYLLO, r[15:8], "lba mid");
            rr(IDX_CYLHI, r[23:16], "lba high");
            u_host_model.read_reg(IDX_DEVHEAD, rd_v);
            check("lba top", rd_v[3:0], r[27:24]);
         end
      end
      $display("test seek done");
      do_reset();
      chk_flags();
      $display("test second reset done");
      final_report();
   end
endmodule : test_seek_sense_setfeature_cmds
`default_nettype wire
